// File: amp_protection_sequencer.sv
// fault supervisor and restart sequencer for a two-channel switching power stage
`timescale 1ns/10ps
module amp_protection_sequencer #(
  parameter int unsigned MS_CYC = amp_prot_pkg::MS_CYC_DEF
) (
  input wire logic clk_i, // 25 MHz core clock
  input wire logic resetn_i, // async reset, active low
  input wire amp_prot_pkg::apb_req_s apb_i, // apb request group
  output logic [31:0] prdata_o, // apb read data
  output logic pready_o, // apb ready
  output logic pslverr_o, // apb error on unmapped address
  input wire logic [1:0] mode_i, // decoded mode pin, async
  input wire logic ilim_i, // current limit comparator, async
  input wire logic win_short_i, // output window check: rail short, async
  input wire logic uv_i, // supply_low_guard comparator, async
  input wire logic ov_i, // supply_high_guard comparator, async
  input wire logic ub_i, // supply_imbalance_guard comparator, async
  input wire logic [7:0] temp_c_i, // junction temperature in C, core clock
  output logic [7:0] gain_o, // thermal_gain_rollback gain, ff = full
  output logic mute_o, // input stages off, outputs idle at 50 %
  output logic stage_en_o, // power stage switching
  output logic current_limit_o, // regulate output level at the current limit
  output logic fault_flag_n_o, // fault_flag_n drive level, always low
  output logic fault_flag_oe_o, // fault_flag_n pulled low while high
  output logic irq_o // level interrupt
);
  import amp_prot_pkg::*;

  core_s q;
  core_s n;
  pins_s p;
  logic tick;
  logic hot;
  logic lim_on;
  logic trip;
  logic stby;
  logic supply_off;
  logic acc;
  logic wr;
  logic hit;
  logic [EV_W-1:0] ev_set;
  logic [EV_W-1:0] ev_clr;
  logic [31:0] rd;

  ////////////////////////////////////////////////////////////////////////////
  // pin conditioning

  sync_agree #(
    .W($bits(pins_s))
  ) u_pins (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .d_i({mode_i, ilim_i, win_short_i, uv_i, ov_i, ub_i}),
    .q_o(p)
  );

  ////////////////////////////////////////////////////////////////////////////
  // fault conditions

  always_comb begin
    hot = temp_c_i > OT_TRIP_C;
    supply_off = p.uv | p.ub;
    // limiting only counts while the stage is actually switching
    lim_on = p.ilim & q.stage_en;
    trip = lim_on & (q.lim >= LIM_W'(TAU_CYC));
    stby = (p.mode != MODE_MUTE && p.mode != MODE_OPER) | q.force_stby;
    acc = apb_i.psel & apb_i.penable;
    wr = acc & apb_i.pwrite;
    hit = apb_i.paddr == A_CTRL || apb_i.paddr == A_STATE ||
          apb_i.paddr == A_EVENT || apb_i.paddr == A_MASK;
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  always_comb begin
    n = q;
    // millisecond timebase; ms counter saturates so long waits stay valid
    tick = q.pre == PRE_W'(MS_CYC - 1);
    n.pre = tick ? '0 : q.pre + 1'b1;
    if (tick && q.ms != 8'hff) begin
      n.ms = q.ms + 8'h01;
    end
    // persistence counter clears on any gap in limiting
    n.lim = lim_on ? q.lim + 1'b1 : '0;

    case (q.st)
      ST_STANDBY: begin
        if (!stby) begin
          n.st = ST_WINDOW;
        end
      end
      ST_WINDOW: begin
        // stages stay off while the check sees a rail short
        if (!p.win_short) begin
          n.st = ST_MUTE;
          n.ms = 8'h00;
          n.pre = '0;
        end
      end
      ST_MUTE: begin
        if (q.ms >= T_RUN_MS && p.mode == MODE_OPER) begin
          n.st = ST_RUN;
        end
      end
      ST_RUN: begin
        if (p.mode == MODE_MUTE) begin
          n.st = ST_MUTE;
        end
      end
      ST_OC_OFF: begin
        if (q.ms >= T_MUTE_MS) begin
          if (p.win_short) begin
            n.ms = T_MUTE_MS;
          end else begin
            n.st = ST_MUTE;
          end
        end
      end
      ST_HOLD: begin
        if (q.ms >= T_SUPPLY_MS) begin
          n.st = ST_WINDOW;
        end
      end
      default: begin
        n.st = ST_STANDBY;
      end
    endcase

    if (trip) begin
      n.st = ST_OC_OFF;
      n.ms = 8'h00;
      n.pre = '0;
    end
    // restart delay runs from the moment the supply fault clears
    if (supply_off && q.st != ST_STANDBY) begin
      n.st = ST_HOLD;
      n.ms = 8'h00;
      n.pre = '0;
    end
    if (stby) begin
      n.st = ST_STANDBY;
    end

    // over-temperature and over-voltage gate without leaving the state,
    // so the stage returns as soon as they clear
    n.stage_en = (n.st == ST_MUTE || n.st == ST_RUN) & ~hot & ~p.ov;
    n.mute = n.st == ST_MUTE || temp_c_i >= TF_MUTE_C;
    n.climit = lim_on;

    if (temp_c_i <= TF_START_C) begin
      n.gain = GAIN_FULL;
    end else if (temp_c_i >= TF_MUTE_C) begin
      n.gain = 8'h00;
    end else begin
      n.gain = 8'((TF_MUTE_C - temp_c_i) * GAIN_STEP);
    end

    // flag node: low while limiting, for 50 ms after a trip and while a rail short
    // is seen at a window check
    n.flag_low = lim_on
                 | (n.st == ST_OC_OFF && (n.ms < T_FLAG_REL_MS || n.ms >= T_MUTE_MS))
                 | (n.st == ST_WINDOW && p.win_short);

    ////////////////////////////////////////////////////////////////////////
    // events and registers

    ev_set = '0;
    ev_set[EV_OT] = hot;
    ev_set[EV_TRIP] = trip;
    ev_set[EV_WIN] = (q.st == ST_WINDOW || q.st == ST_OC_OFF) & p.win_short;
    ev_set[EV_UV] = p.uv;
    ev_set[EV_OV] = p.ov;
    ev_set[EV_UB] = p.ub;
    ev_set[EV_LIM] = lim_on;
    ev_clr = (wr && apb_i.paddr == A_EVENT) ? apb_i.pwdata[EV_W-1:0] : '0;
    // a new event in the clearing cycle survives the clear
    n.evt = (q.evt & ~ev_clr) | ev_set;

    if (wr && apb_i.paddr == A_CTRL) begin
      n.force_stby = apb_i.pwdata[CF_STBY];
    end
    if (wr && apb_i.paddr == A_MASK) begin
      n.mask = apb_i.pwdata[EV_W-1:0];
    end

    rd = '0;
    case (apb_i.paddr)
      A_CTRL: begin
        rd[CF_STBY] = q.force_stby;
      end
      A_STATE: begin
        rd[SF_EN] = q.stage_en;
        rd[SF_MUTE] = q.mute;
        rd[SF_LIM] = q.climit;
        rd[SF_FLAG] = q.flag_low;
        rd[SF_ST +: 3] = q.st;
        rd[SF_GAIN +: 8] = q.gain;
      end
      A_EVENT: begin
        rd[EV_W-1:0] = q.evt;
      end
      A_MASK: begin
        rd[EV_W-1:0] = q.mask;
      end
      default: begin
        rd = '0;
      end
    endcase
    // read data is captured in the setup cycle so prdata comes from a flop
    if (apb_i.psel && !apb_i.penable && !apb_i.pwrite) begin
      n.rdata = rd;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q <= '0;
      q.st <= ST_STANDBY;
      q.mask <= MASK_RST;
    end else begin
      q <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign prdata_o = q.rdata;
  assign pready_o = acc;
  assign pslverr_o = acc & ~hit;
  assign gain_o = q.gain;
  assign mute_o = q.mute;
  assign stage_en_o = q.stage_en;
  assign current_limit_o = q.climit;
  // open drain: never drives high, a released node is biased high outside
  assign fault_flag_n_o = 1'b0;
  assign fault_flag_oe_o = q.flag_low;
  assign irq_o = |(q.evt & q.mask);

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  sequence s_oc_early;
    q.st == ST_OC_OFF && q.ms < T_FLAG_REL_MS;
  endsequence

  sequence s_oc_released;
    q.st == ST_OC_OFF && q.ms >= T_FLAG_REL_MS && q.ms < T_MUTE_MS;
  endsequence

  sequence s_rail_short_seen;
    q.st == ST_OC_OFF && q.ms >= T_MUTE_MS && p.win_short;
  endsequence

  sequence s_quiet_supply;
    !stby && !supply_off && !trip;
  endsequence

  chk_fold_mute: assert property (
    temp_c_i >= TF_MUTE_C |=> gain_o == 8'h00 && mute_o
  ) else $error("gain not zero at full foldback");

  chk_fold_full: assert property (
    temp_c_i <= TF_START_C |=> gain_o == GAIN_FULL
  ) else $error("gain reduced below foldback start");

  chk_hot_gate: assert property (
    hot |=> !stage_en_o
  ) else $error("stage enabled while over temperature");

  chk_hot_return: assert property (
    (q.st == ST_RUN && !hot && !p.ov && p.mode == MODE_OPER) ##0 s_quiet_supply
    |=> stage_en_o
  ) else $error("stage not back after temperature cleared");

  chk_lim_switching: assert property (
    (lim_on && !trip && !hot && !p.ov && q.st == ST_RUN && p.mode == MODE_OPER)
    ##0 s_quiet_supply |=> stage_en_o && current_limit_o
  ) else $error("limiting stopped the outputs");

  chk_trip_off: assert property (
    trip && !stby && !supply_off |=> q.st == ST_OC_OFF && !stage_en_o && fault_flag_oe_o
  ) else $error("trip did not shut down");

  chk_trip_count: assert property (
    trip |-> $past(q.lim) == LIM_W'(TAU_CYC - 1)
  ) else $error("trip not after the persistence time");

  chk_lim_flag: assert property (
    lim_on |=> fault_flag_oe_o
  ) else $error("flag not low during limiting");

  chk_oc_early: assert property (
    s_oc_early |-> fault_flag_oe_o && !stage_en_o
  ) else $error("flag not low in first 50 ms");

  chk_oc_release: assert property (
    s_oc_released |-> !fault_flag_oe_o && !stage_en_o
  ) else $error("flag not released between 50 and 100 ms");

  chk_rail_hold: assert property (
    s_rail_short_seen ##0 s_quiet_supply |=> q.st == ST_OC_OFF && fault_flag_oe_o
  ) else $error("restart despite rail short");

  chk_window_block: assert property (
    q.st == ST_WINDOW && p.win_short |=> !stage_en_o
  ) else $error("stage enabled during window fault");

  chk_supply_hold: assert property (
    supply_off && q.st != ST_STANDBY && !stby |=> q.st == ST_HOLD && q.ms == 8'h00
  ) else $error("supply fault did not hold off");

  chk_hold_delay: assert property (
    $rose(q.st == ST_WINDOW) && $past(q.st) == ST_HOLD |-> $past(q.ms) >= T_SUPPLY_MS
  ) else $error("restart before 100 ms delay");

  chk_ov_gate: assert property (
    p.ov |=> !stage_en_o
  ) else $error("stage enabled during over voltage");

  chk_mute_idle: assert property (
    q.st == ST_MUTE |-> mute_o
  ) else $error("mute state without input disable");

  chk_start_mute: assert property (
    $rose(q.st == ST_RUN) |-> $past(q.st) == ST_MUTE && $past(q.ms) >= T_RUN_MS
  ) else $error("operation entered before start-up mute");

  chk_hold_off: assert property (
    q.st == ST_HOLD || q.st == ST_OC_OFF || q.st == ST_STANDBY |-> !stage_en_o
  ) else $error("stage on during shutdown fault");

  chk_event_keep: assert property (
    ev_set[EV_OV] |=> q.evt[EV_OV]
  ) else $error("event lost in clearing cycle");

  chk_irq_level: assert property (
    q.evt[EV_TRIP] && q.mask[EV_TRIP] |-> irq_o
  ) else $error("unmasked event without interrupt");

endmodule

// File: amp_prot_pkg.sv
// shared constants, types and register map of the amplifier protection sequencer
//
// How it works
// - above 145 C gain falls step by step, fully muted at 155 C, stage stays on.
// - above 160 C power stage drops at once, returns directly when temperature clears.
// - current limiting only regulates output level; outputs keep switching, no shutdown.
// - limiting held continuously longer than tau trips overcurrent and shuts down.
// - fault flag is pulled low during limiting and after an overcurrent trip.
// - after trip: flag released at 50 ms, mute at 100 ms, run at 150 ms, repeating.
// - at the 100 ms point the window check runs; a rail short holds flag low.
// - every standby-to-mute start runs the window check first; a rail short halts start-up.
// - supply low switches off silently; restart 100 ms after supply recovers.
// - supply high drops the stages; they return as soon as supply is back, no delay.
// - supply imbalance switches off; restart 100 ms after it clears.
// - mute keeps both stages switching at 50 % with inputs disabled.
// - start-up holds mute about 150 ms before operation, even if operation is asked.
package amp_prot_pkg;
  localparam int unsigned CLK_MHZ = 25;
  localparam int unsigned MS_US = 1000;
  localparam int unsigned MS_CYC_DEF = MS_US * CLK_MHZ;
  localparam int unsigned TAU_US = 40;
  localparam int unsigned TAU_CYC = TAU_US * CLK_MHZ;
  localparam int unsigned PRE_W = 16;
  localparam int unsigned LIM_W = 12;
  localparam int unsigned EV_W = 7;
  localparam logic [7:0] T_FLAG_REL_MS = 8'h32;
  localparam logic [7:0] T_MUTE_MS = 8'h64;
  localparam logic [7:0] T_RUN_MS = 8'h96;
  localparam logic [7:0] T_SUPPLY_MS = 8'h64;
  localparam logic [7:0] TF_START_C = 8'h91;
  localparam logic [7:0] TF_MUTE_C = 8'h9b;
  localparam logic [7:0] OT_TRIP_C = 8'ha0;
  localparam logic [7:0] GAIN_FULL = 8'hff;
  localparam logic [7:0] GAIN_STEP = 8'h19;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STATE = 8'h04;
  localparam logic [7:0] A_EVENT = 8'h08;
  localparam logic [7:0] A_MASK = 8'h0c;
  localparam int unsigned CF_STBY = 0;
  localparam int unsigned SF_EN = 0;
  localparam int unsigned SF_MUTE = 1;
  localparam int unsigned SF_LIM = 2;
  localparam int unsigned SF_FLAG = 3;
  localparam int unsigned SF_ST = 4;
  localparam int unsigned SF_GAIN = 8;
  localparam int unsigned EV_OT = 0;
  localparam int unsigned EV_TRIP = 1;
  localparam int unsigned EV_WIN = 2;
  localparam int unsigned EV_UV = 3;
  localparam int unsigned EV_OV = 4;
  localparam int unsigned EV_UB = 5;
  localparam int unsigned EV_LIM = 6;
  localparam logic [EV_W-1:0] MASK_RST = 7'h00;
  typedef enum logic [1:0] {
    MODE_STBY = 2'b00,
    MODE_MUTE = 2'b01,
    MODE_OPER = 2'b10
  } mode_e;
  typedef enum logic [2:0] {
    ST_STANDBY = 3'b000,
    ST_WINDOW = 3'b001,
    ST_MUTE = 3'b010,
    ST_RUN = 3'b011,
    ST_OC_OFF = 3'b100,
    ST_HOLD = 3'b101
  } st_e;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_s;
  typedef struct packed {
    logic [1:0] mode;
    logic ilim;
    logic win_short;
    logic uv;
    logic ov;
    logic ub;
  } pins_s;
  typedef struct packed {
    st_e st;
    logic [PRE_W-1:0] pre;
    logic [7:0] ms;
    logic [LIM_W-1:0] lim;
    logic force_stby;
    logic [EV_W-1:0] evt;
    logic [EV_W-1:0] mask;
    logic [31:0] rdata;
    logic [7:0] gain;
    logic mute;
    logic stage_en;
    logic flag_low;
    logic climit;
  } core_s;
endpackage

// File: sync_agree.sv
// three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/10ps
module sync_agree #(
  parameter int W = 7
) (
  input wire logic clk_i, // core clock
  input wire logic resetn_i, // async reset, active low
  input wire logic [W-1:0] d_i, // raw asynchronous levels
  output logic [W-1:0] q_o // filtered levels
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } sync_s;

  sync_s q;
  sync_s n;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    n = q;
    n.s1 = d_i;
    // s1 feeds only s2: it may be metastable
    n.s2 = q.s1;
    n.s3 = q.s2;
    for (int i = 0; i < W; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        n.q[i] = q.s3[i];
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign q_o = q.q;
endmodule

// File: flag_monitor.sv
// external controller model: drives the mode pin and classifies the fault flag pattern
`timescale 1ns/10ps
module flag_monitor #(
  parameter int unsigned HOLD_CYC = 3000
) (
  input wire logic clk_i, // core clock
  input wire logic resetn_i, // async reset, active low
  input wire logic flag_drv_i, // drive level of the open-drain flag
  input wire logic flag_oe_i, // flag pulled low while high
  input wire logic [1:0] mode_req_i, // mode wanted by the bench
  output logic [1:0] mode_o, // mode pin as driven
  output logic rail_short_o, // flag held low for HOLD_CYC cycles
  output logic load_short_o // flag went low again after a release
);
  ////////////////////////////////////////////////////////////////////////////////
  logic pin;
  logic was_low;
  logic seen_rel;
  logic [15:0] low_cnt;
  // no pull-up here, the read-out stage alone biases a released node high
  assign pin = flag_oe_i ? flag_drv_i : 1'b1;
  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mode_o <= 2'h0;
      was_low <= 1'b0;
      seen_rel <= 1'b0;
      low_cnt <= 16'h0000;
      rail_short_o <= 1'b0;
      load_short_o <= 1'b0;
    end else begin
      mode_o <= mode_req_i;
      was_low <= !pin;
      if (!pin) begin
        if (low_cnt < 16'(HOLD_CYC)) begin
          low_cnt <= low_cnt + 16'h0001;
        end else begin
          rail_short_o <= 1'b1;
        end
        if (seen_rel) begin
          load_short_o <= 1'b1;
        end
      end else begin
        low_cnt <= 16'h0000;
        if (was_low) begin
          seen_rel <= 1'b1;
        end
      end
    end
  end
endmodule

// File: tb.sv
// self-checking bench for the amplifier protection sequencer
`timescale 1ns/10ps
module tb;
  import amp_prot_pkg::*;
  // short millisecond keeps the restart sequences within a few thousand cycles
  localparam int unsigned MSC = 20;
  logic clk_i, resetn_i, ilim, win_short, uv, ov, ub, err;
  logic pready, pslverr, mute, stage_en, climit, flag_drv, flag_oe, irq;
  logic rail_short, load_short;
  apb_req_s apb;
  logic [31:0] prdata, rd;
  logic [1:0] mode_req, mode;
  logic [7:0] temp, gain;
  int failures, total_checks;
  amp_protection_sequencer #(.MS_CYC(MSC)) u_amp_protection_sequencer (
    .clk_i(clk_i), .resetn_i(resetn_i), .apb_i(apb), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .mode_i(mode), .ilim_i(ilim), .win_short_i(win_short), .uv_i(uv),
    .ov_i(ov), .ub_i(ub), .temp_c_i(temp), .gain_o(gain), .mute_o(mute),
    .stage_en_o(stage_en), .current_limit_o(climit), .fault_flag_n_o(flag_drv),
    .fault_flag_oe_o(flag_oe), .irq_o(irq));
  flag_monitor #(.HOLD_CYC(3000)) u_flag_monitor (.clk_i(clk_i), .resetn_i(resetn_i),
    .flag_drv_i(flag_drv), .flag_oe_i(flag_oe), .mode_req_i(mode_req), .mode_o(mode),
    .rail_short_o(rail_short), .load_short_o(load_short));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    if (failures == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic ms(input int n);
    cyc(n * MSC);
  endtask
  // bits: stage enabled, muted, flag pulled low
  task automatic outs(input logic [2:0] e);
    check("stage_mute_flag", {29'h0000_0000, stage_en, mute, flag_oe}, {29'h0000_0000, e});
  endtask
  task automatic apb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    apb.psel <= 1'b1;
    apb.penable <= 1'b0;
    apb.pwrite <= wr;
    apb.paddr <= a;
    apb.pwdata <= d;
    @(posedge clk_i);
    apb.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    if (n >= 50) begin
      failures++;
      give_verdict();
    end
    apb.psel <= 1'b0;
    apb.penable <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] msk,
      input logic [31:0] exp, input logic eerr);
    apb_xfer(1'b0, a, 32'h0000_0000);
    check(nm, rd & msk, exp);
    check("pslverr", {31'h0000_0000, err}, {31'h0000_0000, eerr});
  endtask
  // a hung stage shows up as a timeout, not a silent pass
  task automatic wait_off(input int bound);
    int n;
    n = 0;
    while (stage_en !== 1'b0 && n < bound) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= bound) begin
      failures++;
      give_verdict();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  initial begin
    cyc(90000);
    failures++;
    give_verdict();
  end
  initial begin
    resetn_i = 1'b0;
    apb = '0;
    mode_req = 2'h0;
    {ilim, win_short, uv, ov, ub} = 5'h00;
    temp = 8'h19;
    failures = 0;
    total_checks = 0;
    cyc(16);
    resetn_i <= 1'b1;
    cyc(1);
    check("flag_drv", {31'h0000_0000, flag_drv}, 32'h0000_0000);
    check("pready_idle", {31'h0000_0000, pready}, 32'h0000_0000);
    rd_chk("ctrl", A_CTRL, 32'hffff_ffff, 32'h0000_0000, 1'b0);
    rd_chk("mask", A_MASK, 32'hffff_ffff, 32'h0000_0000, 1'b0);
    rd_chk("event", A_EVENT, 32'hffff_ffff, 32'h0000_0000, 1'b0);
    apb_xfer(1'b1, A_STATE, 32'hffff_ffff);
    rd_chk("state", A_STATE, 32'h0000_007f, 32'h0000_0000, 1'b0);
    rd_chk("unmapped", 8'h10, 32'hffff_ffff, 32'h0000_0000, 1'b1);
    mode_req <= MODE_OPER;
    ms(140);
    outs(3'h6);
    ms(20);
    outs(3'h4);
    ////////////////////////////////////////////////////////////////////////////
    temp <= 8'h91;
    cyc(4);
    check("gain_145", {24'h00_0000, gain}, 32'h0000_00ff);
    temp <= 8'h96;
    cyc(4);
    check("gain_150", {24'h00_0000, gain}, 32'h0000_007d);
    temp <= 8'h9b;
    cyc(4);
    check("gain_155", {24'h00_0000, gain}, 32'h0000_0000);
    outs(3'h6);
    temp <= 8'ha1;
    cyc(4);
    outs(3'h2);
    check("irq_masked", {31'h0000_0000, irq}, 32'h0000_0000);
    apb_xfer(1'b1, A_MASK, 32'h0000_0003);
    check("irq_on", {31'h0000_0000, irq}, 32'h0000_0001);
    temp <= 8'h96;
    cyc(4);
    outs(3'h4);
    rd_chk("state_run", A_STATE, 32'h0000_0070, 32'h0000_0030, 1'b0);
    temp <= 8'h19;
    cyc(4);
    apb_xfer(1'b1, A_EVENT, 32'h0000_0001);
    check("irq_clr", {31'h0000_0000, irq}, 32'h0000_0000);
    ////////////////////////////////////////////////////////////////////////////
    ilim <= 1'b1;
    cyc(100);
    outs(3'h5);
    check("climit", {31'h0000_0000, climit}, 32'h0000_0001);
    ilim <= 1'b0;
    cyc(10);
    outs(3'h4);
    ilim <= 1'b1;
    cyc(900);
    outs(3'h5);
    wait_off(300);
    ilim <= 1'b0;
    outs(3'h1);
    check("irq_trip", {31'h0000_0000, irq}, 32'h0000_0001);
    ms(45);
    outs(3'h1);
    ms(10);
    outs(3'h0);
    ms(40);
    outs(3'h0);
    ms(10);
    outs(3'h6);
    ms(40);
    outs(3'h6);
    ms(10);
    outs(3'h4);
    ilim <= 1'b1;
    wait_off(1500);
    ilim <= 1'b0;
    win_short <= 1'b1;
    check("load_short", {31'h0000_0000, load_short}, 32'h0000_0001);
    ms(120);
    outs(3'h1);
    ms(180);
    check("rail_short", {31'h0000_0000, rail_short}, 32'h0000_0001);
    win_short <= 1'b0;
    ms(5);
    outs(3'h6);
    ms(150);
    outs(3'h4);
    ////////////////////////////////////////////////////////////////////////////
    for (int k = 0; k < 2; k++) begin
      if (k == 0) uv <= 1'b1;
      else ub <= 1'b1;
      cyc(10);
      outs(3'h0);
      ms(20);
      uv <= 1'b0;
      ub <= 1'b0;
      ms(95);
      outs(3'h0);
      ms(10);
      outs(3'h6);
      ms(150);
      outs(3'h4);
    end
    ov <= 1'b1;
    cyc(10);
    outs(3'h0);
    ov <= 1'b0;
    cyc(10);
    outs(3'h4);
    mode_req <= MODE_MUTE;
    ms(1);
    outs(3'h6);
    mode_req <= MODE_OPER;
    ms(1);
    outs(3'h4);
    ////////////////////////////////////////////////////////////////////////////
    mode_req <= MODE_STBY;
    ms(2);
    outs(3'h0);
    win_short <= 1'b1;
    mode_req <= MODE_OPER;
    ms(20);
    outs(3'h1);
    rd_chk("state_win", A_STATE, 32'h0000_0070, 32'h0000_0010, 1'b0);
    win_short <= 1'b0;
    ms(5);
    outs(3'h6);
    ms(155);
    outs(3'h4);
    apb_xfer(1'b1, A_CTRL, 32'h0000_0001);
    cyc(5);
    outs(3'h0);
    rd_chk("ctrl_set", A_CTRL, 32'hffff_ffff, 32'h0000_0001, 1'b0);
    apb_xfer(1'b1, A_CTRL, 32'h0000_0000);
    rd_chk("event_all", A_EVENT, 32'hffff_ffff, 32'h0000_007e, 1'b0);
    apb_xfer(1'b1, A_EVENT, 32'h0000_007f);
    rd_chk("event_clr", A_EVENT, 32'hffff_ffff, 32'h0000_0000, 1'b0);
    check("irq_none", {31'h0000_0000, irq}, 32'h0000_0000);
    give_verdict();
  end
endmodule
